// *** common/rate_si_defs.vh ***
// Constants of the rate-select and signal-integrity register block.
// Assumes inclusion by bare name from the design files.
`ifndef RATE_SI_DEFS_VH
`define RATE_SI_DEFS_VH

// 7-bit 2-wire address of the diagnostics page (A2h as 8-bit)
`define DEV_ADDR            7'h51

// Byte offsets on the diagnostics page
`define OFS_TX_EQ_HIGH      8'h28
`define OFS_TX_EQ_LOW       8'h29
`define OFS_RX_OUTPUT_EMPHASIS_LEVEL_HIGH    8'h2A
`define OFS_RX_OUTPUT_EMPHASIS_LEVEL_LOW     8'h2B
`define OFS_CHECKSUM        8'h5F
`define OFS_STATUS_CTRL     8'h6E
`define OFS_SOFT_TX_POWER   8'h76

// Status/control byte fields
`define BIT_TX_PIN_STATE    5
`define BIT_RX_PIN_STATE    4
`define BIT_RX_RATE_CTRL    3

// Soft transmit rate / power level byte fields
`define BIT_TX_RATE_CTRL    3
`define BIT_POWER_STATE     1
`define BIT_POWER_SELECT    0

// Equalisation and emphasis fields
`define EQ_BOOST_BIT        0
`define OUTPUT_EMPHASIS_LEVEL_MSB            2
`define OUTPUT_EMPHASIS_LEVEL_LSB            0

// Reset and special values
`define SI_FACTORY_VALUE    8'h00
`define SI_RESTORE_CODE     8'hFF
`define CSUM_BASE_VALUE     8'h00
`define RATE_CTRL_RESET     1'b0
`define UNMAPPED_READ       8'h00

`endif

// *** rtl/line_sampler.v ***
// Edge detector for one 2-wire bus line.
// Assumes the line is already synchronous to the core clock.
`timescale 1ns/1ps
module line_sampler (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Line
  input  wire din,
  output wire level,
  output wire rise,
  output wire fall
);

  reg cur_r;
  reg prev_r;

  // Idle bus lines float high
  always @(posedge clk) begin
    if (rst) begin
      cur_r  <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      cur_r  <= din;
      prev_r <= cur_r;
    end
  end

  assign level = cur_r;
  assign rise  = cur_r & ~prev_r;
  assign fall  = ~cur_r & prev_r;

endmodule

// *** rtl/rate_path.v ***
// Rate decision for one direction: effective rate, clock-recovery use
// and the matching signal-integrity setting.
// Assumes pin and soft bit are synchronous to the core clock.
`timescale 1ns/1ps
module rate_path #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Rate sources
  input  wire         rate_pin,
  input  wire         rate_ctrl,
  // Settings per rate
  input  wire [W-1:0] set_high,
  input  wire [W-1:0] set_low,
  // Results
  output reg          rate_high,
  output reg          cdr_enable,
  output reg  [W-1:0] setting
);

  wire eff_high;

  assign eff_high = rate_pin | rate_ctrl;

  always @(posedge clk) begin
    if (rst) begin
      rate_high  <= 1'b0;
      cdr_enable <= 1'b0;
      setting    <= {W{1'b0}};
    end else begin
      rate_high  <= eff_high;
      cdr_enable <= eff_high;
      setting    <= eff_high ? set_high : set_low;
    end
  end

endmodule

// *** rtl/rate_select_si_config.v ***
// Rate-select and signal-integrity configuration of an optical module,
// with its 2-wire management slave for the diagnostics page.
// Assumes SCL and SDA are synchronous to CORE_CLK and sampled at 200 MHz.
//
// Contract
// - Byte 118 bit 3 is the read/write soft transmit rate control.
// - Byte 118 bit 1 always reads zero, lowest power level.
// - Byte 118 bit 0 writes are ignored; power level stays zero.
// - Effective transmit rate is transmit pin OR soft transmit bit.
// - Transmit equalisation from byte 40 at high rate, byte 41 at low.
// - Only the equalisation LSB counts: zero none, one 6 dB boost.
// - Receive emphasis from byte 42 at high rate, byte 43 at low.
// - Emphasis level is the low three bits; zero means no emphasis.
// - Writing FFh to bytes 40 to 43 restores the zero dB default.
// - Checksum byte 95 is refreshed within 100 ms of any change.
// - Receive and transmit rates are set independently of each other.
// - Byte 110 bits 4 and 5 mirror receive and transmit pins.
// - Rates set by byte 110 bit 3 and byte 118 bit 3.
// - Both soft rate bits are low after power-on.
// - Effective receive rate is receive pin OR soft receive bit.
// - Soft commands take effect within 100 ms of the write.
`timescale 1ns/1ps
`include "rate_si_defs.vh"
module rate_select_si_config #(
  parameter [7:0] CSUM_BASE = `CSUM_BASE_VALUE
) (
  // Clock and reset
  input  wire       CORE_CLK,
  input  wire       SYS_RST,
  // 2-wire management interface
  input  wire       SCL_IN,
  input  wire       SDA_IN,
  output wire       SDA_OUT,
  output wire       SDA_OE,
  // Rate select pins
  input  wire       TX_RATE_SELECT_PIN,
  input  wire       RX_RATE_SELECT_PIN,
  // Transmit path controls
  output wire       TX_RATE_HIGH,
  output wire       TX_CDR_ENABLE,
  output wire       TX_EQ_BOOST,
  // Receive path controls
  output wire       RX_RATE_HIGH,
  output wire       RX_CDR_ENABLE,
  output wire [2:0] OUTPUT_EMPHASIS_LEVEL
);

  // Protocol states
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ADDR  = 3'd1;
  localparam [2:0] ST_AACK  = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_WACK  = 3'd4;
  localparam [2:0] ST_RDATA = 3'd5;
  localparam [2:0] ST_RACK  = 3'd6;

  // Line events
  wire       scl_lvl;
  wire       scl_rise;
  wire       scl_fall;
  wire       sda_lvl;
  wire       sda_rise;
  wire       sda_fall;
  wire       start_det;
  wire       stop_det;

  // Protocol engine
  reg  [2:0] state_r;
  reg  [2:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg        full_r;
  reg        rw_r;
  reg        first_r;
  reg        nack_r;
  reg  [7:0] ptr_r;
  reg        sda_oe_r;

  // Write strobe towards the register file
  reg        wr_stb_r;
  reg  [7:0] wr_addr_r;
  reg  [7:0] wr_data_r;

  // Register file
  reg  [7:0] tx_eq_high_r;
  reg  [7:0] tx_eq_low_r;
  reg  [7:0] rx_output_emphasis_level_high_r;
  reg  [7:0] rx_output_emphasis_level_low_r;
  reg        tx_rate_control_r;
  reg        rx_rate_control_r;
  reg  [7:0] checksum_r;
  reg  [7:0] checksum_nxt;
  reg  [7:0] si_wr_value;
  reg  [7:0] rd_data;

  // Selected fields per direction
  wire       tx_eq_high_lsb;
  wire       tx_eq_low_lsb;
  wire [2:0] rx_output_emphasis_level_high_lvl;
  wire [2:0] rx_output_emphasis_level_low_lvl;

  line_sampler u_scl (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .din   (SCL_IN),
    .level (scl_lvl),
    .rise  (scl_rise),
    .fall  (scl_fall)
  );

  line_sampler u_sda (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .din   (SDA_IN),
    .level (sda_lvl),
    .rise  (sda_rise),
    .fall  (sda_fall)
  );

  // Data edges while the clock line is high frame a transfer
  assign start_det = sda_fall & scl_lvl;
  assign stop_det  = sda_rise & scl_lvl;

  // Open-drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_oe_r;

  // Byte served at the current pointer
  always @* begin
    rd_data = `UNMAPPED_READ;
    case (ptr_r)
      `OFS_TX_EQ_HIGH: begin
        rd_data = tx_eq_high_r;
      end
      `OFS_TX_EQ_LOW: begin
        rd_data = tx_eq_low_r;
      end
      `OFS_RX_OUTPUT_EMPHASIS_LEVEL_HIGH: begin
        rd_data = rx_output_emphasis_level_high_r;
      end
      `OFS_RX_OUTPUT_EMPHASIS_LEVEL_LOW: begin
        rd_data = rx_output_emphasis_level_low_r;
      end
      `OFS_CHECKSUM: begin
        rd_data = checksum_r;
      end
      `OFS_STATUS_CTRL: begin
        rd_data[`BIT_TX_PIN_STATE] = TX_RATE_SELECT_PIN;
        rd_data[`BIT_RX_PIN_STATE] = RX_RATE_SELECT_PIN;
        rd_data[`BIT_RX_RATE_CTRL] = rx_rate_control_r;
      end
      `OFS_SOFT_TX_POWER: begin
        rd_data[`BIT_TX_RATE_CTRL] = tx_rate_control_r;
        rd_data[`BIT_POWER_STATE]  = 1'b0;
        rd_data[`BIT_POWER_SELECT] = 1'b0;
      end
      default: begin
        rd_data = `UNMAPPED_READ;
      end
    endcase
  end

  // 2-wire slave: address byte, pointer byte, then data with auto-increment
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 3'd0;
      shift_r   <= 8'h00;
      full_r    <= 1'b0;
      rw_r      <= 1'b0;
      first_r   <= 1'b0;
      nack_r    <= 1'b0;
      ptr_r     <= 8'h00;
      sda_oe_r  <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_det) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 3'd0;
        full_r    <= 1'b0;
        sda_oe_r  <= 1'b0;
      end else if (stop_det) begin
        state_r  <= ST_IDLE;
        full_r   <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_lvl};
              bit_cnt_r <= bit_cnt_r + 3'd1;
              full_r    <= (bit_cnt_r == 3'd7);
            end else if (scl_fall && full_r) begin
              full_r <= 1'b0;
              if (shift_r[7:1] == `DEV_ADDR) begin
                sda_oe_r <= 1'b1;
                rw_r     <= shift_r[0];
                first_r  <= ~shift_r[0];
                state_r  <= ST_AACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 3'd0;
              if (rw_r) begin
                shift_r  <= rd_data;
                sda_oe_r <= ~rd_data[7];
                state_r  <= ST_RDATA;
              end else begin
                sda_oe_r <= 1'b0;
                state_r  <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_lvl};
              bit_cnt_r <= bit_cnt_r + 3'd1;
              full_r    <= (bit_cnt_r == 3'd7);
            end else if (scl_fall && full_r) begin
              full_r   <= 1'b0;
              sda_oe_r <= 1'b1;
              state_r  <= ST_WACK;
              if (first_r) begin
                first_r <= 1'b0;
                ptr_r   <= shift_r;
              end else begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= shift_r;
                ptr_r     <= ptr_r + 8'h01;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe_r  <= 1'b0;
              bit_cnt_r <= 3'd0;
              state_r   <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt_r == 3'd7) begin
                bit_cnt_r <= 3'd0;
                sda_oe_r  <= 1'b0;
                ptr_r     <= ptr_r + 8'h01;
                state_r   <= ST_RACK;
              end else begin
                bit_cnt_r <= bit_cnt_r + 3'd1;
                shift_r   <= {shift_r[6:0], 1'b0};
                sda_oe_r  <= ~shift_r[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_r <= sda_lvl;
            end else if (scl_fall) begin
              if (nack_r) begin
                state_r <= ST_IDLE;
              end else begin
                shift_r  <= rd_data;
                sda_oe_r <= ~rd_data[7];
                state_r  <= ST_RDATA;
              end
            end
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Restore code puts a setting back to its factory value
  always @* begin
    si_wr_value = wr_data_r;
    if (wr_data_r == `SI_RESTORE_CODE) begin
      si_wr_value = `SI_FACTORY_VALUE;
    end
  end

  // Register writes take effect the cycle after the data byte
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tx_eq_high_r      <= `SI_FACTORY_VALUE;
      tx_eq_low_r       <= `SI_FACTORY_VALUE;
      rx_output_emphasis_level_high_r    <= `SI_FACTORY_VALUE;
      rx_output_emphasis_level_low_r     <= `SI_FACTORY_VALUE;
      tx_rate_control_r <= `RATE_CTRL_RESET;
      rx_rate_control_r <= `RATE_CTRL_RESET;
    end else if (wr_stb_r) begin
      case (wr_addr_r)
        `OFS_TX_EQ_HIGH: begin
          tx_eq_high_r <= si_wr_value;
        end
        `OFS_TX_EQ_LOW: begin
          tx_eq_low_r <= si_wr_value;
        end
        `OFS_RX_OUTPUT_EMPHASIS_LEVEL_HIGH: begin
          rx_output_emphasis_level_high_r <= si_wr_value;
        end
        `OFS_RX_OUTPUT_EMPHASIS_LEVEL_LOW: begin
          rx_output_emphasis_level_low_r <= si_wr_value;
        end
        `OFS_STATUS_CTRL: begin
          rx_rate_control_r <= wr_data_r[`BIT_RX_RATE_CTRL];
        end
        `OFS_SOFT_TX_POWER: begin
          // Power level select is not stored
          tx_rate_control_r <= wr_data_r[`BIT_TX_RATE_CTRL];
        end
        default: begin
          tx_rate_control_r <= tx_rate_control_r;
        end
      endcase
    end
  end

  // Checksum follows the settings one cycle after any change
  always @* begin
    checksum_nxt = CSUM_BASE + tx_eq_high_r + tx_eq_low_r
                 + rx_output_emphasis_level_high_r + rx_output_emphasis_level_low_r;
  end

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      checksum_r <= CSUM_BASE;
    end else begin
      checksum_r <= checksum_nxt;
    end
  end

  // Only the decoded fields reach the analog settings
  assign tx_eq_high_lsb   = tx_eq_high_r[`EQ_BOOST_BIT];
  assign tx_eq_low_lsb    = tx_eq_low_r[`EQ_BOOST_BIT];
  assign rx_output_emphasis_level_high_lvl = rx_output_emphasis_level_high_r[`OUTPUT_EMPHASIS_LEVEL_MSB:`OUTPUT_EMPHASIS_LEVEL_LSB];
  assign rx_output_emphasis_level_low_lvl  = rx_output_emphasis_level_low_r[`OUTPUT_EMPHASIS_LEVEL_MSB:`OUTPUT_EMPHASIS_LEVEL_LSB];

  // Each direction has its own pin and soft bit
  rate_path #(
    .W (1)
  ) u_tx_path (
    .clk        (CORE_CLK),
    .rst        (SYS_RST),
    .rate_pin   (TX_RATE_SELECT_PIN),
    .rate_ctrl  (tx_rate_control_r),
    .set_high   (tx_eq_high_lsb),
    .set_low    (tx_eq_low_lsb),
    .rate_high  (TX_RATE_HIGH),
    .cdr_enable (TX_CDR_ENABLE),
    .setting    (TX_EQ_BOOST)
  );

  rate_path #(
    .W (3)
  ) u_rx_path (
    .clk        (CORE_CLK),
    .rst        (SYS_RST),
    .rate_pin   (RX_RATE_SELECT_PIN),
    .rate_ctrl  (rx_rate_control_r),
    .set_high   (rx_output_emphasis_level_high_lvl),
    .set_low    (rx_output_emphasis_level_low_lvl),
    .rate_high  (RX_RATE_HIGH),
    .cdr_enable (RX_CDR_ENABLE),
    .setting    (OUTPUT_EMPHASIS_LEVEL)
  );

endmodule

// *** test/rate_si_monitor.sv ***
// Concurrent checks on the rate-select block ports.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/1ps
module rate_si_monitor (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       SYS_RST,
  // Bus
  input wire logic       SCL_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  // Pins
  input wire logic       TX_RATE_SELECT_PIN,
  input wire logic       RX_RATE_SELECT_PIN,
  // Path controls
  input wire logic       TX_RATE_HIGH,
  input wire logic       TX_CDR_ENABLE,
  input wire logic       TX_EQ_BOOST,
  input wire logic       RX_RATE_HIGH,
  input wire logic       RX_CDR_ENABLE,
  input wire logic [2:0] OUTPUT_EMPHASIS_LEVEL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Bus quiet long enough for any write to have landed
  sequence idle;
    SCL_IN [*8];
  endsequence
  // Data line may only ever be pulled low
  a_sda_open_drain: assert property (!SDA_OUT)
    else $error("data line driven high");
  a_tx_rate_or: assert property (TX_RATE_SELECT_PIN |=> TX_RATE_HIGH)
    else $error("tx rate low with pin high");
  a_rx_rate_or: assert property (RX_RATE_SELECT_PIN |=> RX_RATE_HIGH)
    else $error("rx rate low with pin high");
  a_tx_cdr_use: assert property (TX_CDR_ENABLE == TX_RATE_HIGH)
    else $error("tx clock recovery wrong");
  a_rx_cdr_use: assert property (RX_CDR_ENABLE == RX_RATE_HIGH)
    else $error("rx clock recovery wrong");
  a_eq_steady: assert property (idle ##0 $stable(TX_RATE_HIGH) |-> $stable(TX_EQ_BOOST))
    else $error("tx boost moved");
  a_output_emphasis_level_steady: assert property (idle ##0 $stable(RX_RATE_HIGH) |->
    $stable(OUTPUT_EMPHASIS_LEVEL))
    else $error("emphasis moved");
  a_tx_rate_steady: assert property (idle ##0 $stable(TX_RATE_SELECT_PIN) |=>
    $stable(TX_RATE_HIGH))
    else $error("tx rate moved");
  a_rx_rate_steady: assert property (idle ##0 $stable(RX_RATE_SELECT_PIN) |=>
    $stable(RX_RATE_HIGH))
    else $error("rx rate moved");
  c_soft_tx: cover property (TX_RATE_HIGH && !TX_RATE_SELECT_PIN);
  c_ack: cover property ($rose(SDA_OE));
  c_output_emphasis_level_on: cover property (OUTPUT_EMPHASIS_LEVEL != 3'h0);
endmodule
bind rate_select_si_config rate_si_monitor mon (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .TX_RATE_SELECT_PIN(TX_RATE_SELECT_PIN),
  .RX_RATE_SELECT_PIN(RX_RATE_SELECT_PIN), .TX_RATE_HIGH(TX_RATE_HIGH),
  .TX_CDR_ENABLE(TX_CDR_ENABLE), .TX_EQ_BOOST(TX_EQ_BOOST), .RX_RATE_HIGH(RX_RATE_HIGH),
  .RX_CDR_ENABLE(RX_CDR_ENABLE), .OUTPUT_EMPHASIS_LEVEL(OUTPUT_EMPHASIS_LEVEL));

// *** test/host_master.sv ***
// Host-side 2-wire master for the management port.
// Assumes the bench resolves SDA with a pull-up from both drivers.
`timescale 1ns/1ps
`include "rate_si_defs.vh"
module host_master (
  // Clock
  input  wire logic clk,
  // Bus
  output logic      scl,
  output logic      sda_lo,
  input  wire logic sda
);
  initial begin
    scl = 1'h1;
    sda_lo = 1'h0;
  end
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wbit(input logic b);
    sda_lo = !b;
    tick(4);
    scl = 1'h1;
    tick(4);
    scl = 1'h0;
    tick(1);
  endtask
  task rbit(output logic b);
    sda_lo = 1'h0;
    tick(4);
    scl = 1'h1;
    tick(2);
    b = sda;
    tick(2);
    scl = 1'h0;
    tick(1);
  endtask
  // Release SDA for 4 cycles before raising SCL, then pull SDA low while SCL is high
  task start;
    sda_lo = 1'h0;
    tick(4);
    scl = 1'h1;
    tick(4);
    sda_lo = 1'h1;
    tick(4);
    scl = 1'h0;
    tick(1);
  endtask
  task stop;
    sda_lo = 1'h1;
    tick(4);
    scl = 1'h1;
    tick(4);
    sda_lo = 1'h0;
    tick(4);
  endtask
  task wbyte(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    ok = ok & !a;
  endtask
  task write(input logic [7:0] a, d, output logic ok);
    ok = 1'h1;
    start;
    wbyte({`DEV_ADDR, 1'h0}, ok);
    wbyte(a, ok);
    wbyte(d, ok);
    stop;
  endtask
  task read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'h1;
    start;
    wbyte({`DEV_ADDR, 1'h0}, ok);
    wbyte(a, ok);
    start;
    wbyte({`DEV_ADDR, 1'h1}, ok);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(1'h1);
    stop;
  endtask
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the rate-select block.
// Assumes open-drain SDA with a pull-up resolved here.
`timescale 1ns/1ps
`include "rate_si_defs.vh"
module testbench;
  logic       clk, rst, tx_pin, rx_pin, soft_tx, soft_rx, ok;
  wire logic  scl, sda_lo, sda_oe, sda_out, txh, txc, txb, rxh, rxc;
  wire logic  [2:0] output_emphasis_level;
  wire logic  sda = !(sda_lo | sda_oe);
  logic [7:0] expq[$];
  logic [7:0] si[4];
  logic [7:0] rd_b, b;
  event       rd_ev, snap_ev;
  int         err_count, tests_run;
  integer     seed = 32'h9242A7F1;
  rate_select_si_config DUT (.CORE_CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TX_RATE_SELECT_PIN(tx_pin),
    .RX_RATE_SELECT_PIN(rx_pin), .TX_RATE_HIGH(txh), .TX_CDR_ENABLE(txc),
    .TX_EQ_BOOST(txb), .RX_RATE_HIGH(rxh), .RX_CDR_ENABLE(rxc),
    .OUTPUT_EMPHASIS_LEVEL(output_emphasis_level));
  host_master host (.clk(clk), .scl(scl), .sda_lo(sda_lo), .sda(sda));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  always @(rd_ev) chk(rd_b, expq.pop_front());
  always @(snap_ev) chk({txh, txc, txb, rxh, rxc, output_emphasis_level}, expq.pop_front());
  task report_and_stop;
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, d);
    host.write(a, d, ok);
    expq.push_back(8'h01);
    rd_b = {7'h0, ok};
    -> rd_ev;
  endtask
  task rd(input logic [7:0] a, e);
    expq.push_back(e);
    host.read(a, b, ok);
    rd_b = ok ? b : ~e;
    -> rd_ev;
  endtask
  // Set pins, then note the path controls they should give
  task setp(input logic t, r);
    tx_pin = t;
    rx_pin = r;
    repeat (3) @(negedge clk);
    t = t | soft_tx;
    r = r | soft_rx;
    expq.push_back({t, t, t ? si[0][0] : si[1][0], r, r, r ? si[2][2:0] : si[3][2:0]});
    -> snap_ev;
  endtask
  initial begin
    #300000;
    err_count++;
    report_and_stop;
  end
  initial begin
    rst = 1'h1;
    tx_pin = 1'h0;
    rx_pin = 1'h0;
    soft_tx = 1'h0;
    soft_rx = 1'h0;
    si = '{default: 8'h00};
    repeat (5) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    setp(1'h0, 1'h0);
    rd(`OFS_SOFT_TX_POWER, 8'h00);
    for (int i = 0; i < 4; i++) begin
      setp(i[1], i[0]);
      rd(`OFS_STATUS_CTRL, {2'h0, i[1], i[0], 4'h0});
    end
    for (int n = 0; n < 8; n++) begin
      b = (n % 5 == 1) ? 8'hFF : 8'($random(seed));
      wr(8'(`OFS_TX_EQ_HIGH + n % 4), b);
      si[n % 4] = (b === 8'hFF) ? `SI_FACTORY_VALUE : b;
      rd(8'(`OFS_TX_EQ_HIGH + n % 4), si[n % 4]);
      if (n % 4 == 3) begin
        rd(`OFS_CHECKSUM, `CSUM_BASE_VALUE + si[0] + si[1] + si[2] + si[3]);
        for (int i = 0; i < 4; i++)
          setp(i[1], i[0]);
      end
    end
    setp(1'h0, 1'h0);
    soft_tx = 1'h1;
    wr(`OFS_SOFT_TX_POWER, 8'hFF);
    rd(`OFS_SOFT_TX_POWER, 8'h08);
    setp(1'h0, 1'h0);
    soft_rx = 1'h1;
    wr(`OFS_STATUS_CTRL, 8'h08);
    rd(`OFS_STATUS_CTRL, 8'h08);
    setp(1'h0, 1'h0);
    setp(1'h1, 1'h1);
    soft_tx = 1'h0;
    wr(`OFS_SOFT_TX_POWER, 8'h01);
    rd(`OFS_SOFT_TX_POWER, 8'h00);
    setp(1'h0, 1'h0);
    rd(8'h30, `UNMAPPED_READ);
    repeat (2) @(negedge clk);
    report_and_stop;
  end
endmodule
